// ==== hw/afp_frame.sv ====
`timescale 1ns/1ns
module afp_frame #(
   parameter int RES = afp_pkg::RES_DEFAULT,
   parameter int WAKE_CYC = afp_pkg::WAKE_CYCLES
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic power_down_request_pin,
   input wire logic [RES-1:0] adc_code,
   output logic sdo,
   output logic sdo_oe,
   output logic sample_strobe,
   output logic conv_done,
   output logic acquiring,
   output logic powered_down,
   output logic power_ready,
   output logic mode32
);
   import afp_pkg::*;

   localparam logic [CNT_W-1:0] CONV_EDGE =
      (RES == 12) ? CONV_EDGE_12 :
      (RES == 10) ? CONV_EDGE_10 : CONV_EDGE_8;
   localparam logic [WAKE_W-1:0] WAKE_END = WAKE_W'(WAKE_CYC);

   if (!(RES == 12 || RES == 10 || RES == 8)) begin : g_res_chk
      $error("afp_frame: RES must be 8, 10 or 12");
   end
   if (WAKE_CYC < 1 || WAKE_CYC > 255) begin : g_wake_chk
      $error("afp_frame: WAKE_CYC out of range");
   end

   logic cs_s;
   logic sclk_s;
   logic pd_s;

   afp_sync #(.W(3), .INIT(3'h1)) u_sync (
      .mclk(mclk),
      .arst_n(arst_n),
      .d({sclk, power_down_request_pin, cs_n}),
      .q({sclk_s, pd_s, cs_s})
   );

   logic cs_d_r, cs_d_nxt;
   logic sclk_d_r, sclk_d_nxt;
   logic [CNT_W-1:0] fall_cnt_r, fall_cnt_nxt;
   logic [CNT_W-1:0] rise_cnt_r, rise_cnt_nxt;
   logic rise_seen_r, rise_seen_nxt;
   logic mode32_r, mode32_nxt;
   logic zero_next_r, zero_next_nxt;
   logic conv_busy_r, conv_busy_nxt;
   logic [RES-1:0] result_r, result_nxt;
   logic pd_arm_r, pd_arm_nxt;
   afp_pwr_e pwr_r, pwr_nxt;
   logic [WAKE_W-1:0] wake_cnt_r, wake_cnt_nxt;

   logic cs_fall, cs_rise, sclk_rise, sclk_fall;
   logic sh_load, sh_shift;
   logic [FRAME_BITS-1:0] sh_val;
   logic [CNT_W-1:0] fall_inc, rise_inc;

   assign cs_fall = cs_d_r & ~cs_s;
   assign cs_rise = ~cs_d_r & cs_s;
   // Clock edges only count inside a frame
   assign sclk_rise = ~sclk_d_r & sclk_s & ~cs_s & ~cs_d_r;
   assign sclk_fall = sclk_d_r & ~sclk_s & ~cs_s & ~cs_d_r;
   // Counts saturate so an over-long frame cannot wrap
   assign fall_inc = (&fall_cnt_r) ? fall_cnt_r : fall_cnt_r + 1'b1;
   assign rise_inc = (&rise_cnt_r) ? rise_cnt_r : rise_cnt_r + 1'b1;

   always_comb begin
      cs_d_nxt = cs_s;
      sclk_d_nxt = sclk_s;
      fall_cnt_nxt = fall_cnt_r;
      rise_cnt_nxt = rise_cnt_r;
      rise_seen_nxt = rise_seen_r;
      mode32_nxt = mode32_r;
      zero_next_nxt = zero_next_r;
      conv_busy_nxt = conv_busy_r;
      result_nxt = result_r;
      pd_arm_nxt = pd_arm_r;
      pwr_nxt = pwr_r;
      wake_cnt_nxt = wake_cnt_r;
      sh_load = 1'b0;
      sh_shift = 1'b0;
      sh_val = '0;
      conv_done = 1'b0;
      if (cs_fall) begin
         fall_cnt_nxt = '0;
         rise_cnt_nxt = '0;
         rise_seen_nxt = 1'b0;
         mode32_nxt = 1'b0;
         conv_busy_nxt = 1'b1;
         sh_load = 1'b1;
         // Last frame was long: pad with zeros, else old result
         if (!zero_next_r) begin
            sh_val = {result_r, {(FRAME_BITS-RES){1'b0}}};
         end
      end
      if (sclk_rise) begin
         rise_cnt_nxt = rise_inc;
         rise_seen_nxt = 1'b1;
         if (conv_busy_r && rise_inc == CONV_EDGE) begin
            conv_done = 1'b1;
            conv_busy_nxt = 1'b0;
            result_nxt = adc_code;
            if (pd_arm_r) begin
               pwr_nxt = AFP_PWR_DOWN;
            end
         end
      end
      if (sclk_fall) begin
         fall_cnt_nxt = fall_inc;
         if (fall_inc == RELOAD_FALL) begin
            sh_load = 1'b1;
            sh_val = {result_r, {(FRAME_BITS-RES){1'b0}}};
         end else if (rise_seen_r) begin
            sh_shift = 1'b1;
         end
         if (fall_inc == MODE32_FALL) begin
            // Detection is final here; later halt is harmless
            mode32_nxt = 1'b1;
         end
      end
      if (cs_rise) begin
         zero_next_nxt = mode32_r;
         pd_arm_nxt = pd_s;
         // Aborted conversion leaves the old result in place
         conv_busy_nxt = 1'b0;
         if (!pd_s && pwr_r == AFP_PWR_DOWN) begin
            pwr_nxt = AFP_PWR_WAKE;
            wake_cnt_nxt = '0;
         end
      end
      // Power-down entry wins over a wake that ends in the same cycle
      if (pwr_r == AFP_PWR_WAKE && pwr_nxt == AFP_PWR_WAKE) begin
         if (wake_cnt_r == WAKE_END - 1'b1) begin
            pwr_nxt = AFP_PWR_ON;
         end
         wake_cnt_nxt = wake_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cs_d_r <= RST_HIGH;
         sclk_d_r <= RST_LOW;
         fall_cnt_r <= '0;
         rise_cnt_r <= '0;
         rise_seen_r <= RST_LOW;
         mode32_r <= RST_LOW;
         zero_next_r <= RST_LOW;
         conv_busy_r <= RST_LOW;
         result_r <= '0;
         pd_arm_r <= RST_LOW;
         pwr_r <= AFP_PWR_ON;
         wake_cnt_r <= '0;
      end else begin
         cs_d_r <= cs_d_nxt;
         sclk_d_r <= sclk_d_nxt;
         fall_cnt_r <= fall_cnt_nxt;
         rise_cnt_r <= rise_cnt_nxt;
         rise_seen_r <= rise_seen_nxt;
         mode32_r <= mode32_nxt;
         zero_next_r <= zero_next_nxt;
         conv_busy_r <= conv_busy_nxt;
         result_r <= result_nxt;
         pd_arm_r <= pd_arm_nxt;
         pwr_r <= pwr_nxt;
         wake_cnt_r <= wake_cnt_nxt;
      end
   end

   afp_shifter #(.W(FRAME_BITS)) u_shift (
      .mclk(mclk),
      .arst_n(arst_n),
      .load(sh_load),
      .load_val(sh_val),
      .shift(sh_shift),
      .sdo(sdo)
   );

   // Enable waits one cycle so the loaded MSB is already out
   assign sdo_oe = ~(cs_s | cs_d_r);
   assign sample_strobe = cs_fall;
   assign acquiring = ~conv_busy_r;
   assign powered_down = (pwr_r == AFP_PWR_DOWN);
   assign power_ready = (pwr_r == AFP_PWR_ON);
   assign mode32 = mode32_r;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   property p_zero_pad;
      cs_fall && zero_next_r |=> !sdo;
   endproperty
   a_zero_pad: assert property (p_zero_pad)
      else $error("zero padding missing after long frame");

   property p_msb_first;
      cs_fall && !zero_next_r |=> sdo == result_r[RES-1] && sdo_oe;
   endproperty
   a_msb_first: assert property (p_msb_first)
      else $error("MSB not presented at select fall");

   property p_release;
      cs_s |-> !sdo_oe;
   endproperty
   a_release: assert property (p_release)
      else $error("output driven with select high");

   property p_detect32;
      sclk_fall && fall_cnt_r == MODE32_FALL - 1'b1 |=> mode32_r;
   endproperty
   a_detect32: assert property (p_detect32)
      else $error("long frame not detected");

   property p_reload;
      sclk_fall && fall_cnt_r == RELOAD_FALL - 1'b1
         |=> sdo == result_r[RES-1];
   endproperty
   a_reload: assert property (p_reload)
      else $error("fresh result not reloaded at edge 16");

   property p_conv_end;
      conv_done |-> sclk_rise && rise_cnt_r == CONV_EDGE - 1'b1;
   endproperty
   a_conv_end: assert property (p_conv_end)
      else $error("conversion ended on wrong edge");

   property p_pd_enter;
      conv_done && pd_arm_r |=> powered_down;
   endproperty
   a_pd_enter: assert property (p_pd_enter)
      else $error("power-down not entered at conversion end");

   property p_pd_hold;
      powered_down && !cs_s |=> powered_down;
   endproperty
   a_pd_hold: assert property (p_pd_hold)
      else $error("left power-down while selected");

   property p_pd_sample;
      !cs_rise |=> $stable(pd_arm_r);
   endproperty
   a_pd_sample: assert property (p_pd_sample)
      else $error("request sampled outside select rise");

   property p_restart;
      cs_fall |=> fall_cnt_r == '0 && rise_cnt_r == '0;
   endproperty
   a_restart: assert property (p_restart)
      else $error("edge counts not restarted");

   property p_wake_time;
      $rose(power_ready) |-> $past(wake_cnt_r) == WAKE_END - 1'b1;
   endproperty
   a_wake_time: assert property (p_wake_time)
      else $error("wake settling time wrong");

   property p_sdo_stable;
      !sh_load && !sh_shift |=> $stable(sdo);
   endproperty
   a_sdo_stable: assert property (p_sdo_stable)
      else $error("serial data changed without a clock fall");

   property p_busy_start;
      sample_strobe |=> !acquiring;
   endproperty
   a_busy_start: assert property (p_busy_start)
      else $error("conversion not started at sample");

   property p_long_keep;
      mode32_r && !cs_fall |=> mode32_r;
   endproperty
   a_long_keep: assert property (p_long_keep)
      else $error("long frame flag lost before next frame");

   c_long: cover property (sclk_fall && fall_inc == MODE32_FALL);
   c_pd: cover property (conv_done && pd_arm_r);
   c_wake: cover property ($rose(power_ready));
   c_zero: cover property (cs_fall && zero_next_r);
   c_reload: cover property (sclk_fall && fall_inc == RELOAD_FALL);
endmodule : afp_frame

// ==== hw/afp_pkg.sv ====
package afp_pkg;
   localparam int RES_DEFAULT = 12;
   localparam int FRAME_BITS = 16;
   localparam int CNT_W = 6;
   // Conversion-end rising edge per resolution
   localparam logic [5:0] CONV_EDGE_12 = 6'h0e;
   localparam logic [5:0] CONV_EDGE_10 = 6'h0b;
   localparam logic [5:0] CONV_EDGE_8 = 6'h09;
   // Falling edge that reloads with the fresh result
   localparam logic [5:0] RELOAD_FALL = 6'h10;
   // Falling edge that marks the long frame
   localparam logic [5:0] MODE32_FALL = 6'h1e;
   localparam int CLK_PERIOD_NS = 50;
   localparam int WAKE_TIME_NS = 1000;
   localparam int WAKE_CYCLES =
      (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_W = 8;
   localparam logic RST_LOW = 1'b0;
   localparam logic RST_HIGH = 1'b1;
   typedef enum logic [1:0] {
      AFP_PWR_ON,
      AFP_PWR_DOWN,
      AFP_PWR_WAKE
   } afp_pwr_e;
endpackage : afp_pkg

// ==== hw/afp_sync.sv ====
`timescale 1ns/1ns
module afp_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   import afp_pkg::*;
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_nxt;

   always_comb begin
      meta_nxt = d;
      q_nxt = meta_r;
   end

   // First stage is read by the second stage only
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk or negedge arst_n) begin
         if (!arst_n) begin
            meta_r[i] <= INIT[i];
            q[i] <= INIT[i];
         end else begin
            meta_r[i] <= meta_nxt[i];
            q[i] <= q_nxt[i];
         end
      end
   end
endmodule : afp_sync

// ==== hw/afp_shifter.sv ====
`timescale 1ns/1ns
module afp_shifter #(
   parameter int W = afp_pkg::FRAME_BITS
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   input wire logic shift,
   output logic sdo
);
   import afp_pkg::*;
   logic [W-1:0] word_r;
   logic [W-1:0] word_nxt;

   if (W < 2) begin : g_chk
      $error("afp_shifter: W must be at least 2");
   end

   always_comb begin
      word_nxt = word_r;
      if (load) begin
         word_nxt = load_val;
      end else if (shift) begin
         // Zeros fill in behind the last data bit
         word_nxt = {word_r[W-2:0], 1'b0};
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         word_r <= '0;
      end else begin
         word_r <= word_nxt;
      end
   end

   assign sdo = word_r[W-1];
endmodule : afp_shifter

// ==== tb/afp_host_model.sv ====
`timescale 1ns/1ns
module afp_host_model (
   input wire logic mclk,
   input wire logic sdo,
   input wire logic conv_done,
   input wire logic powered_down,
   input wire logic sdo_oe,
   input wire logic sample_strobe,
   output logic cs_n,
   output logic sclk,
   output logic power_down_request_pin
);
   int rise_idx;
   int conv_at;
   int down_at;
   int up_cnt;
   int strobes;
   int oe_off;
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      power_down_request_pin = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge mclk);
         #1;
         if (conv_done === 1'b1) conv_at = rise_idx;
         if (powered_down === 1'b1 && down_at == 0) down_at = rise_idx;
         if (!cs_n && powered_down !== 1'b1) up_cnt++;
         if (sample_strobe === 1'b1) strobes++;
         if (!cs_n && sdo_oe !== 1'b1) oe_off++;
      end
   endtask : tick
   // Half period of six cycles gives the edge detector margin
   task automatic frame(input int falls, input logic pd, input int hi,
         output logic [31:0] bits);
      bits = '0;
      rise_idx = 0;
      conv_at = 0;
      down_at = 0;
      up_cnt = 0;
      strobes = 0;
      oe_off = 0;
      @(posedge mclk) cs_n <= 1'b0;
      // Pin inverted while selected; only the select rise may count
      power_down_request_pin <= ~pd;
      tick(7);
      for (int i = 0; i < falls; i++) begin
         bits[31-i] = sdo;
         @(posedge mclk) sclk <= 1'b1;
         rise_idx++;
         tick(5);
         @(posedge mclk) sclk <= 1'b0;
         tick(5);
      end
      if (falls < 32) bits[31-falls] = sdo;
      @(posedge mclk) power_down_request_pin <= pd;
      tick(3);
      // Clock stays low after the last fall
      @(posedge mclk) cs_n <= 1'b1;
      tick(hi);
   endtask : frame
endmodule : afp_host_model

// ==== tb/adc_frame_mode_powerdown_test.sv ====
`timescale 1ns/1ns
module adc_frame_mode_powerdown_test;
   import afp_pkg::*;
   logic mclk;
   logic arst_n;
   logic cs_n;
   logic sclk;
   logic pd_pin;
   logic [11:0] adc_code;
   logic sdo;
   logic sdo_oe;
   logic sample_strobe;
   logic acquiring;
   // Host-side minimum acquisition, in clock cycles
   localparam int MIN_ACQUISITION_CYC = 4;
   logic conv_done;
   logic powered_down;
   logic power_ready;
   logic mode32;
   int error_cnt = 0;
   int checked = 0;
   int cycles = 0;
   logic [31:0] b;

   afp_frame #(.RES(12), .WAKE_CYC(2)) dut (
      .mclk(mclk), .arst_n(arst_n), .cs_n(cs_n), .sclk(sclk),
      .power_down_request_pin(pd_pin), .adc_code(adc_code),
      .sdo(sdo), .sdo_oe(sdo_oe), .sample_strobe(sample_strobe),
      .conv_done(conv_done), .acquiring(acquiring),
      .powered_down(powered_down),
      .power_ready(power_ready), .mode32(mode32)
   );
   afp_host_model host (
      .mclk(mclk), .sdo(sdo), .sdo_oe(sdo_oe),
      .sample_strobe(sample_strobe), .conv_done(conv_done),
      .powered_down(powered_down), .cs_n(cs_n), .sclk(sclk),
      .power_down_request_pin(pd_pin)
   );

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish

   // Generous ceiling; the whole run needs a few thousand cycles
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   task automatic set_code(input logic [11:0] c);
      @(posedge mclk) adc_code <= c;
   endtask : set_code

   task automatic t_reset;
      #1;
      check(sdo_oe, 1'b0);
      check(acquiring, 1'b1);
      check(powered_down, 1'b0);
      check(power_ready, 1'b1);
      check(mode32, 1'b0);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_short;
      set_code(12'ha5c);
      host.frame(16, 1'b0, 10, b);
      set_code(12'h3c1);
      host.frame(29, 1'b0, 10, b);
      check(b[31:16], 16'ha5c0);
      check(b[15:2], 14'h0f04);
      check(host.conv_at, 14);
      check(mode32, 1'b0);
      check(sdo_oe, 1'b0);
      check(host.strobes, 1);
      check(host.oe_off, 2);
      $display("t_short done");
   endtask : t_short

   task automatic t_long;
      set_code(12'h9e7);
      host.frame(30, 1'b0, 10, b);
      check(b[15:1], 15'h4f38);
      check(mode32, 1'b1);
      set_code(12'h111);
      host.frame(32, 1'b0, 10, b);
      check(b[31:16], 16'h0000);
      check(b[15:0], 16'h1110);
      set_code(12'h222);
      host.frame(16, 1'b0, 10, b);
      check(b[31:16], 16'h0000);
      check(mode32, 1'b0);
      $display("t_long done");
   endtask : t_long

   task automatic t_pd;
      set_code(12'h5a5);
      host.frame(16, 1'b1, 10, b);
      check(b[31:16], 16'h2220);
      check(powered_down, 1'b0);
      set_code(12'h0c3);
      host.frame(16, 1'b1, 10, b);
      check(host.down_at, 14);
      check(b[31:16], 16'h5a50);
      check(powered_down, 1'b1);
      set_code(12'h7e1);
      host.frame(16, 1'b0, WAKE_CYCLES + MIN_ACQUISITION_CYC + 1,
         b);
      check(host.up_cnt, 0);
      check(b[31:16], 16'h0c30);
      check(powered_down, 1'b0);
      check(power_ready, 1'b1);
      set_code(12'h3e3);
      host.frame(16, 1'b0, 10, b);
      check(b[31:16], 16'h7e10);
      check(host.down_at, 0);
      check(powered_down, 1'b0);
      $display("t_pd done");
   endtask : t_pd

   initial begin
      arst_n = 1'b0;
      adc_code = 12'h000;
      repeat (5) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      t_reset();
      t_short();
      t_long();
      t_pd();
      tally_and_finish();
   end
endmodule : adc_frame_mode_powerdown_test
